// File: hw/smsr_pkg.sv
// Purpose: Shared constants and frame layouts of the switch monitor status bank
// Assumes: 32-bit serial frames, 24-bit register data, 6-bit register offsets
// Notes:   Every offset, field position, reset value and count lives here
package smsr_pkg;

   // Frame length and bit counter marks
   localparam int unsigned FRAME_BITS = 32;             // Bits in one valid frame
   localparam logic [5:0]  CNT_ZERO   = 6'h00;          // No clock edge seen
   localparam logic [5:0]  CNT_FULL   = 6'h20;          // Exactly one frame
   localparam logic [5:0]  CNT_OVER   = 6'h21;          // Saturation: too long

   // Register offsets
   localparam logic [5:0]  OFS_EVENT    = 6'h02;        // Event status, read clears
   localparam logic [5:0]  OFS_CRC      = 6'h03;        // Settings checksum
   localparam logic [5:0]  OFS_COND     = 6'h04;        // Supply and thermal levels
   localparam logic [5:0]  OFS_COMP     = 6'h05;        // Comparator levels
   localparam logic [5:0]  OFS_SETTINGS = 6'h06;        // Programmed settings word
   localparam logic [5:0]  OFS_CONTROL  = 6'h1A;        // Software reset control

   // Event status field positions
   localparam int unsigned EVT_RESET_BIT  = 0;          // Reset occurred
   localparam int unsigned EVT_FRAME_BIT  = 1;          // Wrong frame length
   localparam int unsigned EVT_PARITY_BIT = 2;          // Parity failure

   // Condition status field positions
   localparam int unsigned COND_TSD_BIT = 0;            // Above shutdown temperature
   localparam int unsigned COND_TW_BIT  = 1;            // Above warning temperature
   localparam int unsigned COND_OV_BIT  = 2;            // Supply above over-voltage
   localparam int unsigned COND_UV_BIT  = 3;            // Supply below under-voltage
   localparam int unsigned COND_W       = 4;            // Live condition bits
   localparam int unsigned INPUTS       = 24;           // Switch inputs

   // Control field positions
   localparam int unsigned SWRST_BIT = 0;               // Write 1 to reset the bank

   // Values after reset
   localparam logic [23:0] EVENT_RESET    = 24'h00_0001;
   localparam logic [23:0] SETTINGS_RESET = 24'h00_0000;
   localparam logic [23:0] DATA_ZERO      = 24'h00_0000;
   localparam logic [15:0] CRC_RESET      = 16'hFFFF;

   // Checksum engine
   localparam logic [15:0] CRC_POLY  = 16'h1021;        // CCITT polynomial
   localparam logic [4:0]  CRC_STEPS = 5'h18;           // One step per settings bit

   // Command frame from the host, first bit on the wire is write
   typedef struct packed {
      logic        write;                               // 1 = write, 0 = read
      logic [5:0]  addr;                                // Register offset
      logic [23:0] data;                                // Write data
      logic        parity;                              // Makes the ones count odd
   } smsr_cmd_t;

   // Response frame to the host, first bit on the wire is reset flag
   typedef struct packed {
      logic        reset_flag;                          // Mirror of reset event
      logic        frame_flag;                          // Mirror of frame error
      logic        parity_response_flag;                // Mirror of parity error
      logic [4:0]  rsvd;                                // Reads zero
      logic [23:0] data;                                // Answer to previous read
   } smsr_resp_t;

endpackage

// File: hw/smsr_sync.sv
// Purpose: Two flip-flop synchroniser for levels entering the clk domain
// Assumes: Input bits change slowly against clk, each bit crosses alone
// Notes:   The first stage feeds only the second stage
`timescale 1ns/100ps
module smsr_sync #(
   parameter int unsigned       WIDTH   = 1,
   parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_r;                            // First stage, may settle late
   logic [WIDTH-1:0] stab_r;                            // Second stage, safe to use

   // Two stage capture
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_r <= RST_VAL;
         stab_r <= RST_VAL;
      end else begin
         meta_r <= din;
         stab_r <= meta_r;
      end
   end

   assign dout = stab_r;

endmodule

// File: hw/smsr_regbank.sv
// Purpose: Serial status bank: frame checks, read-clear events, checksum, live levels
// Assumes: Host is a mode 0 serial master with clock far slower than clk
// Notes:   All input pins but clk and sys_rst are synchronised; edges of the serial clock are found on clk
//
// Operation
// RULE1: Odd parity check; even ones drop frame
// RULE2: Parity failure sets event bit two
// RULE3: Parity event mirrored into every response
// RULE4: Count clocked bits; latch only at 32
// RULE5: Wrong bit count sets event bit one
// RULE6: No clock edges means no error
// RULE7: Frame error mirrored into every response
// RULE8: Reading event status clears its bits
// RULE9: Reset event bit resets to one
// RULE10: Any reset restores defaults and state
// RULE11: Reset event mirrored into every response
// RULE12: Checksum at three, CCITT, resets FFFFh
// RULE13: Checksum low sixteen bits, rest zero
// RULE14: Host compares own checksum with register
// RULE15: Condition bit three under-voltage, upper zero
// RULE16: Condition bit two over-voltage level
// RULE17: Condition bit one thermal warning level
// RULE18: Condition bit zero thermal shutdown level
// RULE19: Comparator register, one bit per input
`timescale 1ns/100ps
module smsr_regbank
   import smsr_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              hw_reset_n,
   input  wire logic              spi_sclk,
   input  wire logic              spi_cs_n,
   input  wire logic              spi_mosi,
   output logic                   spi_miso,
   output logic                   spi_miso_oe,
   input  wire logic              undervoltage_level,
   input  wire logic              overvoltage_level,
   input  wire logic              thermal_warning_level,
   input  wire logic              thermal_shutdown_level,
   input  wire logic [INPUTS-1:0] comparator_levels
);

   // Synchronised pins
   logic                sclk_s;                         // Serial clock level
   logic                cs_n_s;                         // Chip select level
   logic                mosi_s;                         // Serial data in
   logic                hw_reset_n_s;                   // Hardware reset pin
   logic [COND_W-1:0]   cond_s;                         // Supply and thermal levels
   logic [INPUTS-1:0]   comp_s;                         // Comparator levels

   // Edge history
   logic                sclk_d_r;                       // Serial clock, one clk late
   logic                cs_n_d_r;                       // Chip select, one clk late
   logic                sclk_rise;                      // Sample edge
   logic                sclk_fall;                      // Launch edge
   logic                cs_fall;                        // Frame start
   logic                cs_rise;                        // Frame end

   // Frame receive state
   logic [5:0]          bit_cnt_r;                      // Bits clocked in this frame
   logic [5:0]          bit_cnt_nxt;                    // Counter next value
   logic [31:0]         rx_r;                           // Shifted-in frame
   smsr_cmd_t           cmd;                            // Frame seen as a command
   logic                frame_len_bad;                  // Frame ended with bad count
   logic                frame_par_bad;                  // Full frame, even ones
   logic                frame_ok;                       // Full frame, odd ones
   logic                rd_event;                       // Valid read of event status
   logic                wr_settings;                    // Valid write of settings
   logic                wr_swrst;                       // Valid software reset write

   // Register state
   logic                reset_all;                      // Any of the three resets
   logic                swrst_r;                        // Software reset pulse
   logic [23:0]         event_r;                        // Event status bits
   logic [23:0]         settings_r;                     // Programmed settings
   logic [15:0]         crc_r;                          // Checksum result
   logic [23:0]         crc_shift_r;                    // Settings bits left to fold
   logic [4:0]          crc_left_r;                     // Steps still to run
   logic                crc_fb;                         // Checksum feedback bit
   logic [23:0]         rd_data;                        // Read mux output
   logic [23:0]         resp_data_r;                    // Data for next response

   // Transmit state
   smsr_resp_t          resp;                           // Response frame to load
   logic [31:0]         tx_r;                           // Outgoing shift register
   logic                miso_r;                         // Serial data out
   logic                miso_oe_r;                      // Serial data out enable

   // Pin synchronisers
   smsr_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_sclk (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     (spi_sclk),
      .dout    (sclk_s)
   );

   smsr_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_cs (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     (spi_cs_n),
      .dout    (cs_n_s)
   );

   smsr_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_mosi (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     (spi_mosi),
      .dout    (mosi_s)
   );

   smsr_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_hwrst (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     (hw_reset_n),
      .dout    (hw_reset_n_s)
   );

   smsr_sync #(.WIDTH(COND_W), .RST_VAL(4'h0)) u_sync_cond (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     ({undervoltage_level, overvoltage_level,
                 thermal_warning_level, thermal_shutdown_level}),
      .dout    (cond_s)
   );

   smsr_sync #(.WIDTH(INPUTS), .RST_VAL(24'h00_0000)) u_sync_comp (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     (comparator_levels),
      .dout    (comp_s)
   );

   // Power-on, hardware pin and software resets act alike
   assign reset_all = sys_rst | ~hw_reset_n_s | swrst_r;   // [RULE10]

   // Edge history of serial clock and chip select
   always_ff @(posedge clk) begin
      if (reset_all) begin
         sclk_d_r <= 1'b0;
         cs_n_d_r <= 1'b1;
      end else begin
         sclk_d_r <= sclk_s;
         cs_n_d_r <= cs_n_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_d_r;
   assign sclk_fall = ~sclk_s & sclk_d_r;
   assign cs_fall   = ~cs_n_s & cs_n_d_r;
   assign cs_rise   = cs_n_s & ~cs_n_d_r;

   // Bit counter saturates one past a full frame so long frames stay visible
   always_comb begin
      bit_cnt_nxt = bit_cnt_r;
      if (cs_fall) begin
         // New frame starts from zero
         bit_cnt_nxt = CNT_ZERO;
      end else if (~cs_n_s && sclk_rise && bit_cnt_r != CNT_OVER) begin
         // One more bit clocked in
         bit_cnt_nxt = bit_cnt_r + 6'h01;                  // [RULE4]
      end
   end

   always_ff @(posedge clk) begin
      if (reset_all) begin
         bit_cnt_r <= CNT_ZERO;
      end else begin
         bit_cnt_r <= bit_cnt_nxt;
      end
   end

   // Receive shift register, bits arrive first bit first
   always_ff @(posedge clk) begin
      if (reset_all) begin
         rx_r <= 32'h0000_0000;
      end else if (~cs_n_s && sclk_rise) begin
         rx_r <= {rx_r[30:0], mosi_s};
      end
   end

   // Frame end checks: length first, then parity
   assign cmd           = smsr_cmd_t'(rx_r);
   assign frame_len_bad = cs_rise && bit_cnt_r != CNT_ZERO
                          && bit_cnt_r != CNT_FULL;        // [RULE5] [RULE6]
   assign frame_par_bad = cs_rise && bit_cnt_r == CNT_FULL
                          && ~(^rx_r);                     // [RULE1]
   assign frame_ok      = cs_rise && bit_cnt_r == CNT_FULL
                          && (^rx_r);                      // [RULE1] [RULE4]

   // Decoded actions of a valid frame
   assign rd_event    = frame_ok && ~cmd.write && cmd.addr == OFS_EVENT;
   assign wr_settings = frame_ok && cmd.write && cmd.addr == OFS_SETTINGS;
   assign wr_swrst    = frame_ok && cmd.write && cmd.addr == OFS_CONTROL
                        && cmd.data[SWRST_BIT];

   // Software reset pulse, one clk long; its reset term uses only the external resets
   always_ff @(posedge clk) begin
      if (sys_rst || ~hw_reset_n_s) begin
         swrst_r <= 1'b0;
      end else begin
         swrst_r <= wr_swrst;
      end
   end

   // Event status: reset bit comes up set, errors set over a clear
   always_ff @(posedge clk) begin
      if (reset_all) begin
         event_r <= EVENT_RESET;                           // [RULE9] [RULE10]
      end else begin
         // Reset indication only ever clears by a read
         event_r[EVT_RESET_BIT] <= event_r[EVT_RESET_BIT] & ~rd_event;   // [RULE8]
         // Frame length error
         event_r[EVT_FRAME_BIT] <= frame_len_bad
                                   | (event_r[EVT_FRAME_BIT] & ~rd_event); // [RULE5] [RULE8]
         // Parity failure
         event_r[EVT_PARITY_BIT] <= frame_par_bad
                                    | (event_r[EVT_PARITY_BIT] & ~rd_event); // [RULE2] [RULE8]
      end
   end

   // Settings register, the only thing software programs here
   always_ff @(posedge clk) begin
      if (reset_all) begin
         settings_r <= SETTINGS_RESET;
      end else if (wr_settings) begin
         settings_r <= cmd.data;
      end
   end

   // Checksum engine folds the settings one bit per clk, first bit highest
   // A read during the 24 steps sees a partial value
   assign crc_fb = crc_r[15] ^ crc_shift_r[23];

   always_ff @(posedge clk) begin
      if (reset_all) begin
         crc_r       <= CRC_RESET;                         // [RULE12]
         crc_shift_r <= SETTINGS_RESET;
         crc_left_r  <= 5'h00;
      end else if (wr_settings) begin
         // Restart from the CCITT seed on every new settings word
         crc_r       <= CRC_RESET;
         crc_shift_r <= cmd.data;
         crc_left_r  <= CRC_STEPS;
      end else if (crc_left_r != 5'h00) begin
         // One polynomial step
         crc_r       <= {crc_r[14:0], 1'b0} ^ (crc_fb ? CRC_POLY : 16'h0000); // [RULE12]
         crc_shift_r <= {crc_shift_r[22:0], 1'b0};
         crc_left_r  <= crc_left_r - 5'h01;
      end
   end

   // Read mux; unmapped offsets and reserved bits answer zero
   always_comb begin
      rd_data = DATA_ZERO;
      unique case (cmd.addr)
         OFS_EVENT: begin
            rd_data = event_r;
         end
         OFS_CRC: begin
            rd_data[15:0] = crc_r;                         // [RULE13]
         end
         OFS_COND: begin
            rd_data[COND_UV_BIT]  = cond_s[COND_UV_BIT];   // [RULE15]
            rd_data[COND_OV_BIT]  = cond_s[COND_OV_BIT];   // [RULE16]
            rd_data[COND_TW_BIT]  = cond_s[COND_TW_BIT];   // [RULE17]
            rd_data[COND_TSD_BIT] = cond_s[COND_TSD_BIT];  // [RULE18]
         end
         OFS_COMP: begin
            rd_data = comp_s;                              // [RULE19]
         end
         OFS_SETTINGS: begin
            rd_data = settings_r;
         end
         default: begin
            rd_data = DATA_ZERO;
         end
      endcase
   end

   // Read answer is held for the next frame; dropped frames leave it alone
   // A write answers zero so old read data is never taken as new
   always_ff @(posedge clk) begin
      if (reset_all) begin
         resp_data_r <= DATA_ZERO;
      end else if (frame_ok && ~cmd.write) begin
         resp_data_r <= rd_data;                           // [RULE4]
      end else if (frame_ok) begin
         resp_data_r <= DATA_ZERO;
      end
   end

   // Response frame with live mirrors of the three event bits
   always_comb begin
      resp                      = '0;
      resp.reset_flag           = event_r[EVT_RESET_BIT];  // [RULE11]
      resp.frame_flag           = event_r[EVT_FRAME_BIT];  // [RULE7]
      resp.parity_response_flag = event_r[EVT_PARITY_BIT]; // [RULE3]
      resp.rsvd                 = 5'h00;
      resp.data                 = resp_data_r;
   end

   // Transmit: load at frame start, advance on falling serial clock
   always_ff @(posedge clk) begin
      if (reset_all) begin
         tx_r   <= 32'h0000_0000;
         miso_r <= 1'b0;
      end else if (cs_fall) begin
         tx_r   <= resp;
         miso_r <= resp.reset_flag;
      end else if (~cs_n_s && sclk_fall) begin
         tx_r   <= {tx_r[30:0], 1'b0};
         miso_r <= tx_r[30];
      end
   end

   // Drive the data out pin only while selected
   always_ff @(posedge clk) begin
      if (reset_all) begin
         miso_oe_r <= 1'b0;
      end else begin
         miso_oe_r <= ~cs_n_s;
      end
   end

   assign spi_miso    = miso_r;
   assign spi_miso_oe = miso_oe_r;

endmodule

// File: verif/smsr_regbank_asserts.sv
// Purpose: Port-level checks of the serial status bank
// Assumes: Host keeps mode 0, frames far slower than clk
// Notes:   Helper logic rebuilds each frame from the pins
`timescale 1ns/100ps
module smsr_regbank_asserts
   import smsr_pkg::*;
(
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire logic              hw_reset_n,
   input wire logic              spi_sclk,
   input wire logic              spi_cs_n,
   input wire logic              spi_mosi,
   input wire logic              spi_miso,
   input wire logic              spi_miso_oe,
   input wire logic              undervoltage_level,
   input wire logic              overvoltage_level,
   input wire logic              thermal_warning_level,
   input wire logic              thermal_shutdown_level,
   input wire logic [INPUTS-1:0] comparator_levels
);
   logic        sclk_d;  // Serial clock one clk ago
   logic        cs_d;    // Chip select one clk ago
   logic [5:0]  cnt;     // Rising serial edges this frame
   logic [31:0] sh_in;   // Command bits seen
   logic [31:0] rsp;     // Response bits seen
   logic        p_len;   // Previous frame had a wrong length
   logic        p_par;   // Previous frame failed parity
   logic        p_rd;    // Previous frame was a valid read
   logic        p_wr;    // Previous frame was a valid write
   logic [5:0]  p_ofs;   // Offset of previous frame
   logic        p_d0;    // Data bit zero of previous frame
   wire         cs_rise = spi_cs_n & ~cs_d;
   wire         n32     = (cnt == CNT_FULL);
   wire         ok      = n32 & (^sh_in);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Pin edge history
   always_ff @(posedge clk) begin
      sclk_d <= sys_rst ? 1'b0 : spi_sclk;
      cs_d   <= sys_rst ? 1'b1 : spi_cs_n;
   end
   // Count and collect command bits on rising serial edges
   always_ff @(posedge clk) begin
      if (sys_rst || cs_rise) begin
         cnt <= CNT_ZERO;
      end else if (!spi_cs_n && spi_sclk && !sclk_d && cnt != CNT_OVER) begin
         cnt   <= cnt + 6'h01;
         sh_in <= {sh_in[30:0], spi_mosi};
      end
   end
   // Collect response bits just before each falling serial edge moves them
   always_ff @(posedge clk) begin
      if (!spi_cs_n && !spi_sclk && sclk_d) begin
         rsp <= {rsp[30:0], spi_miso};
      end
   end
   // Remember what the last clocked frame was; clock-less frames leave it alone
   always_ff @(posedge clk) begin
      if (sys_rst || !hw_reset_n) begin
         {p_len, p_par, p_rd, p_wr, p_ofs, p_d0} <= '0;
      end else if (cs_rise && cnt != CNT_ZERO) begin
         p_len <= !n32;
         p_par <= n32 && !(^sh_in);
         p_rd  <= ok && !sh_in[31];
         p_wr  <= ok && sh_in[31];
         p_ofs <= sh_in[30:25];
         p_d0  <= sh_in[1];
      end
   end
   AST_HWRST_QUIET: assert property ((!hw_reset_n) [*4] |=> !spi_miso_oe && !spi_miso)
      else $error("Outputs active during hardware reset");
   AST_PAR_FLAG: assert property ($rose(spi_cs_n) && n32 && p_par |-> rsp[29])
      else $error("Parity flag missing after bad parity frame");
   AST_LEN_FLAG: assert property (cs_rise && n32 && p_len |-> rsp[30])
      else $error("Frame flag missing after wrong length frame");
   AST_RC_CLEAR: assert property (cs_rise && n32 && p_rd && p_ofs == OFS_EVENT
      |-> rsp[31:29] == 3'h0)
      else $error("Event flags not cleared by event read");
   AST_CRC_RSVD: assert property (cs_rise && n32 && p_rd && p_ofs == OFS_CRC
      |-> rsp[23:16] == 8'h00)
      else $error("Checksum upper bits not zero");
   AST_COND: assert property (cs_rise && n32 && p_rd
      && p_ofs == OFS_COND |-> rsp[23:0] == {20'h0_0000, undervoltage_level,
      overvoltage_level, thermal_warning_level, thermal_shutdown_level})
      else $error("Condition register mismatch");
   AST_COMP: assert property (cs_rise && n32 && p_rd && p_ofs == OFS_COMP
      |-> rsp[23:0] == comparator_levels)
      else $error("Comparator register mismatch");
   AST_SWRST: assert property (cs_rise && n32 && p_wr
      && p_ofs == OFS_CONTROL && p_d0 |-> rsp[31])
      else $error("Reset flag missing after software reset");
   COV_PAR: cover property (cs_rise && n32 && p_par);
   COV_LEN: cover property (cs_rise && n32 && p_len);
   COV_SWRST: cover property (cs_rise && n32 && p_wr && p_ofs == OFS_CONTROL);
endmodule
bind smsr_regbank smsr_regbank_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
   .hw_reset_n(hw_reset_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
   .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .undervoltage_level(undervoltage_level),
   .overvoltage_level(overvoltage_level), .thermal_warning_level(thermal_warning_level),
   .thermal_shutdown_level(thermal_shutdown_level), .comparator_levels(comparator_levels));

// File: verif/smsr_host_model.sv
// Purpose: Serial host that sends frames of any length to the bank
// Assumes: Mode 0, serial period 8 clk (320 ns), pins moved on falling clk
// Notes:   Data line shows the inverse of its last bit while deselected
`timescale 1ns/100ps
module smsr_host_model
   import smsr_pkg::*;
(
   input  wire logic clk,
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_mosi,
   input  wire logic spi_miso,
   input  wire logic spi_miso_oe
);
   // Idle link: clock low, deselected
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // One frame of n clocked bits; bits past 32 are zero
   task automatic xfer(input logic [31:0] c, input int n, output logic [31:0] r);
      r = '0;
      @(negedge clk);
      spi_cs_n = 1'b0;
      repeat (8) @(negedge clk);
      for (int i = 0; i < n; i++) begin
         spi_mosi = (i < 32) ? c[31-i] : 1'b0;
         repeat (4) @(negedge clk);
         spi_sclk = 1'b1;
         repeat (4) @(negedge clk);
         // Settled long before the falling edge; an undriven line reads inverted
         r = {r[30:0], spi_miso_oe ? spi_miso : ~spi_miso};
         spi_sclk = 1'b0;
      end
      repeat (4) @(negedge clk);
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;        // Released line does not keep its value
      repeat (8) @(negedge clk);
   endtask
   // Host side checksum of a settings word, MSB first
   function automatic logic [15:0] crc16(input logic [23:0] d);
      logic [15:0] s;
      s = CRC_RESET;
      for (int i = 23; i >= 0; i--) begin
         s = {s[14:0], 1'b0} ^ ((s[15] ^ d[i]) ? CRC_POLY : 16'h0000);
      end
      return s;
   endfunction
endmodule

// File: verif/smsr_regbank_tb.sv
// Purpose: Frame level test of the serial status bank
// Assumes: Host model drives the link, bench drives levels and resets
// Notes:   Each response carries the read data of the previous valid frame, zero after a write
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module smsr_regbank_tb
   import smsr_pkg::*;
;
   logic              clk;
   logic              sys_rst;
   logic              hw_reset_n;
   logic              spi_sclk;
   logic              spi_cs_n;
   logic              spi_mosi;
   logic              spi_miso;
   logic              spi_miso_oe;
   logic [3:0]        lv;      // UV, OV, TW, TSD
   logic [INPUTS-1:0] comp;    // Comparator pattern
   logic [23:0]       sv;      // Settings word written
   int                n_fail;
   int                total_checks;
   int                cyc;
   smsr_regbank dut (.clk(clk), .sys_rst(sys_rst), .hw_reset_n(hw_reset_n),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .spi_miso_oe(spi_miso_oe), .undervoltage_level(lv[3]), .overvoltage_level(lv[2]),
      .thermal_warning_level(lv[1]), .thermal_shutdown_level(lv[0]),
      .comparator_levels(comp));
   smsr_host_model host (.clk(clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
   // Clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Command word with odd parity
   function automatic logic [31:0] mk(input logic w, input logic [5:0] a, input logic [23:0] d);
      smsr_cmd_t c;
      c = '{w, a, d, ~^{w, a, d}};
      return c;
   endfunction
   // Expected response: reset, frame, parity flags and data
   function automatic logic [31:0] ex(input logic [2:0] f, input logic [23:0] d);
      smsr_resp_t r;
      r = '{f[2], f[1], f[0], 5'h00, d};
      return r;
   endfunction
   // One frame; full frames have their response compared
   task automatic fr(input logic [31:0] c, input int n, input logic [31:0] e);
      logic [31:0] r;
      host.xfer(c, n, r);
      if (n == 32) `CHK(r, e)
   endtask
   // Summary and verdict
   task automatic print_verdict;
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         print_verdict;
      end
   end
   // Main sequence
   initial begin
      {n_fail, total_checks, cyc} = '0;
      sys_rst = 1'b1;
      hw_reset_n = 1'b1;
      lv = 4'hA;
      comp = 24'hC3_5A81;
      sv = 24'h12_3456;
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge clk);
      fr(mk(0, OFS_EVENT, 0), 32, ex(3'h4, 0));
      fr(mk(0, OFS_CRC, 0), 32, ex(3'h0, 24'h00_0001));
      fr(mk(0, OFS_COND, 0), 32, ex(3'h0, 24'h00_FFFF));
      fr(mk(0, OFS_COMP, 0), 32, ex(3'h0, 24'h00_000A));
      lv = 4'h5;
      fr(mk(0, OFS_COND, 0), 32, ex(3'h0, comp));
      fr(mk(0, OFS_EVENT, 0), 32, ex(3'h0, 24'h00_0005));
      fr(mk(1, OFS_SETTINGS, sv) ^ 32'h0000_0001, 32, ex(3'h0, 0));
      fr(mk(0, OFS_SETTINGS, 0), 32, ex(3'h1, 0));
      fr(mk(0, OFS_EVENT, 0), 32, ex(3'h1, 0));
      fr(mk(0, OFS_EVENT, 0), 32, ex(3'h0, 24'h00_0004));
      fr(mk(0, OFS_EVENT, 0), 0, 0);
      fr(mk(0, OFS_EVENT, 0), 32, ex(3'h0, 0));
      fr(mk(1, OFS_SETTINGS, sv), 31, 0);
      fr(mk(1, OFS_SETTINGS, sv), 33, 0);
      fr(mk(0, OFS_SETTINGS, 0), 32, ex(3'h2, 0));
      fr(mk(0, OFS_EVENT, 0), 32, ex(3'h2, 0));
      fr(mk(0, OFS_CRC, 0), 32, ex(3'h0, 24'h00_0002));
      fr(mk(1, OFS_SETTINGS, sv), 32, ex(3'h0, 24'h00_FFFF));
      fr(mk(0, OFS_CRC, 0), 32, ex(3'h0, 0));
      fr(mk(0, OFS_COMP, 0), 32, ex(3'h0, {8'h00, host.crc16(sv)}));
      fr(mk(1, OFS_CONTROL, 24'h00_0001), 32, ex(3'h0, comp));
      fr(mk(0, OFS_SETTINGS, 0), 32, ex(3'h4, 0));
      fr(mk(0, OFS_CRC, 0), 32, ex(3'h4, 0));
      fr(mk(0, OFS_EVENT, 0), 32, ex(3'h4, 24'h00_FFFF));
      fr(mk(1, OFS_SETTINGS, 24'h00_00FF), 32, ex(3'h0, 24'h00_0001));
      @(negedge clk);
      hw_reset_n = 1'b0;
      repeat (6) @(negedge clk);
      hw_reset_n = 1'b1;
      repeat (6) @(negedge clk);
      fr(mk(0, OFS_SETTINGS, 0), 32, ex(3'h4, 0));
      fr(mk(0, OFS_EVENT, 0), 32, ex(3'h4, 0));
      fr(mk(0, 6'h3F, 0), 32, ex(3'h0, 24'h00_0001));
      fr(mk(0, OFS_CRC, 0), 32, ex(3'h0, 0));
      print_verdict;
   end
endmodule
